/* File: design/spm_master.sv */
// Summary of operation
// - Rx irq while rx level at/above watermark
// - Tx irq while tx level at/below watermark
// - Timeout after 32 idle sck with data
// - Timeout clears on empty, frame, clear
// - Overrun flags full queue, keeps contents
// - No overrun while flow control enabled
// - Underrun resends stale word, sticky flag
// - Tx-empty irq while tx queue empty
// - Mode 00: send queue, store all
// - Mode 01: send queue, store nothing
// - Mode 10 empty queue: dummy, decrement first
// - Mode 10 queued data sent first, no decrement
// - Receive mode halts at zero count
// - Dummy phase ignores newly queued words
// - Mode 11: decrement tx count per word
// - Mode 11: then dummies, decrementing rx count
// - Mode 11 stop conditions
// - Finish one counter before the other
// - Mode change takes effect next word
// - Format 0 four-wire, 2 three-wire
// - Three-wire: command out, data in
// - Busy drops when exchange ends
// - Masked sources ORed onto one line
// - Frame bits are size field plus one, at least 4
`timescale 1ns/10ps
`default_nettype none
module spm_master #(
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i, // Peripheral clock
  input wire logic rstn_i, // Async reset, active low
  input wire logic link_clk_i, // Bit clock, twice sck rate
  input wire logic port_enable_bit_i, // Port enable
  input wire logic [1:0] frame_format_sel_i, // Frame format
  input wire logic [1:0] master_xfer_mode_i, // Transfer mode
  input wire logic [4:0] data_size_sel_i, // Data bits minus one
  input wire logic [4:0] command_size_sel_i, // Command bits minus one
  input wire logic [31:0] dummy_char_value_i, // Dummy word
  input wire logic hw_flow_ctrl_i, // Flow control enable
  input wire logic continuous_i, // Keep clocking on empty queue, four-wire mode 00 only
  input wire logic [AW:0] rx_watermark_i, // Rx trigger level
  input wire logic [AW:0] tx_watermark_i, // Tx trigger level
  input wire logic rx_frm_wr_i, // Load rx frame count
  input wire logic [31:0] rx_frm_data_i, // Rx frame count value
  input wire logic tx_frm_wr_i, // Load tx frame count
  input wire logic [31:0] tx_frm_data_i, // Tx frame count value
  output logic [31:0] rx_frame_count_o, // Rx frame count
  output logic [31:0] tx_frame_count_o, // Tx frame count
  input wire logic [5:0] irq_mask_bits_i, // Interrupt mask
  input wire logic [5:0] irq_clear_port_i, // Clear pulses
  output logic [5:0] irq_raw_o, // Raw sources
  output logic irq_o, // Combined interrupt
  output logic busy_o, // Exchange in flight
  input wire logic tx_valid_i, // Tx word offered
  input wire logic [31:0] tx_data_i, // Tx word
  output logic tx_ready_o, // Tx queue has room
  output logic rx_valid_o, // Rx word available
  output logic [31:0] rx_data_o, // Rx word
  input wire logic rx_ready_i, // Rx word taken
  output logic [AW:0] tx_level_o, // Tx queue level
  output logic [AW:0] rx_level_o, // Rx queue level
  output logic sck_o, // Serial clock
  output logic cs_n_o, // Slave select, active low
  output logic sout_o, // Serial data out
  output logic sout_oe_o, // Serial out enable
  input wire logic sin_i // Serial data in
);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  // Frame length from a size field, reserved values clamped
  function automatic logic [6:0] frame_bits(input logic [4:0] sz);
    logic [4:0] s;
    s = (sz < spm_pkg::SIZE_MIN) ? spm_pkg::SIZE_MIN : sz;
    return {2'h0, s} + 7'h01;
  endfunction

  // Core-domain state
  typedef struct packed {
    logic [1:0] rst;
    logic [DEPTH-1:0][31:0] txm;
    logic [AW-1:0] txw;
    logic [AW-1:0] txr;
    logic [AW:0] txc;
    logic [DEPTH-1:0][31:0] rxm;
    logic [AW-1:0] rxw;
    logic [AW-1:0] rxr;
    logic [AW:0] rxc;
    logic [31:0] rxcnt;
    logic [31:0] txfcnt;
    spm_pkg::spm_seq_type seq;
    logic dummy_ph;
    logic [1:0] use_cnt;
    logic cur_store;
    logic cur_3w;
    logic [31:0] cur_word;
    logic [6:0] cur_bits;
    logic [6:0] cur_cmd;
    logic req_tgl;
    logic [2:0] dn_s;
    logic dn_seen;
    logic [2:0] tk_s;
    logic tk_seen;
    logic [5:0] tocnt;
    logic rto;
    logic ror;
    logic tur;
  } spm_core_type;

  // Link-domain state
  typedef struct packed {
    logic [1:0] rst;
    logic [2:0] rq_s;
    logic rq_seen;
    spm_pkg::spm_lnk_type st;
    logic sck;
    logic cs_n;
    logic oe;
    logic three;
    logic [6:0] idx;
    logic [6:0] total;
    logic [6:0] cmd;
    logic [31:0] sh;
    logic [31:0] rxsh;
    logic [31:0] rxw;
    logic done_tgl;
    logic fdiv;
    logic tick_tgl;
  } spm_link_type;

  spm_core_type c_reg, c_next;
  spm_link_type l_reg, l_next;

  // Core next state
  always_comb begin
    logic push;
    logic pop;
    logic rpop;
    logic rpush;
    logic go;
    logic dn_ev;
    logic tk_ev;
    logic [31:0] w;
    logic ovr_ev; // Overrun event this cycle
    logic udr_ev; // Underrun launch this cycle
    ovr_ev = 1'b0;
    udr_ev = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    rpop = 1'b0;
    rpush = 1'b0;
    go = 1'b0;
    dn_ev = 1'b0;
    tk_ev = 1'b0;
    w = c_reg.cur_word;
    c_next = c_reg;
    c_next.rst = {c_reg.rst[0], 1'b1};
    // Return toggles pass three flops, counted when last two agree
    c_next.dn_s = {c_reg.dn_s[1:0], l_reg.done_tgl};
    c_next.tk_s = {c_reg.tk_s[1:0], l_reg.tick_tgl};
    dn_ev = (c_reg.dn_s[1] == c_reg.dn_s[2]) && (c_reg.dn_s[2] != c_reg.dn_seen);
    tk_ev = (c_reg.tk_s[1] == c_reg.tk_s[2]) && (c_reg.tk_s[2] != c_reg.tk_seen);
    if (dn_ev) begin
      c_next.dn_seen = c_reg.dn_s[2];
    end
    if (tk_ev) begin
      c_next.tk_seen = c_reg.tk_s[2];
    end
    // Queue side handshakes
    push = tx_valid_i && (c_reg.txc != FULL);
    rpop = rx_ready_i && (c_reg.rxc != '0);
    if (push) begin
      c_next.txm[c_reg.txw] = tx_data_i;
      c_next.txw = c_reg.txw + 1'b1;
    end
    if (rpop) begin
      c_next.rxr = c_reg.rxr + 1'b1;
    end
    // Launch a word; mode is sampled only here
    if (c_reg.seq == spm_pkg::SEQ_IDLE && port_enable_bit_i) begin
      if (frame_format_sel_i == spm_pkg::FMT_THREE_WIRE) begin
        if (c_reg.txc != '0) begin
          pop = 1'b1;
          c_next.cur_store = 1'b1;
        end
      end else if (frame_format_sel_i == spm_pkg::FMT_FOUR_WIRE) begin
        case (master_xfer_mode_i)
          spm_pkg::MODE_DUPLEX: begin
            if (c_reg.txc != '0) begin
              pop = 1'b1;
              c_next.cur_store = 1'b1;
            end else if (continuous_i) begin
              go = 1'b1; // Last launched word goes out again
              c_next.tur = 1'b1;
              udr_ev = 1'b1;
              c_next.cur_store = 1'b1;
            end
          end
          spm_pkg::MODE_TXONLY: begin
            if (c_reg.txc != '0) begin
              pop = 1'b1;
              c_next.cur_store = 1'b0;
            end
          end
          spm_pkg::MODE_RECV: begin
            if (c_reg.rxcnt != '0) begin
              c_next.cur_store = 1'b1;
              if (!c_reg.dummy_ph && c_reg.txc != '0) begin
                pop = 1'b1;
              end else begin
                go = 1'b1;
                w = dummy_char_value_i;
                c_next.rxcnt = c_reg.rxcnt - 32'h1;
                c_next.dummy_ph = 1'b1;
              end
            end
          end
          default: begin
            c_next.cur_store = 1'b1;
            if (c_reg.use_cnt != spm_pkg::USE_RXCNT && c_reg.txfcnt != '0) begin
              if (c_reg.txc != '0) begin
                pop = 1'b1;
                c_next.txfcnt = c_reg.txfcnt - 32'h1;
                c_next.use_cnt = (c_reg.txfcnt == 32'h1) ? spm_pkg::USE_NONE :
                  spm_pkg::USE_TXCNT;
              end
            end else if (c_reg.rxcnt != '0 && c_reg.txc == '0) begin
              go = 1'b1;
              w = dummy_char_value_i;
              c_next.rxcnt = c_reg.rxcnt - 32'h1;
              c_next.use_cnt = (c_reg.rxcnt == 32'h1) ? spm_pkg::USE_NONE :
                spm_pkg::USE_RXCNT;
            end
          end
        endcase
      end
      if (pop) begin
        w = c_reg.txm[c_reg.txr];
        c_next.txr = c_reg.txr + 1'b1;
      end
      // Flow control holds off a storing word while rx queue is full
      if ((pop || go) && hw_flow_ctrl_i && c_next.cur_store && c_reg.rxc == FULL) begin
        c_next = c_reg;
        c_next.rst = {c_reg.rst[0], 1'b1};
        c_next.dn_s = {c_reg.dn_s[1:0], l_reg.done_tgl};
        c_next.tk_s = {c_reg.tk_s[1:0], l_reg.tick_tgl};
        c_next.dn_seen = dn_ev ? c_reg.dn_s[2] : c_reg.dn_seen;
        c_next.tk_seen = tk_ev ? c_reg.tk_s[2] : c_reg.tk_seen;
        if (push) begin
          c_next.txm[c_reg.txw] = tx_data_i;
          c_next.txw = c_reg.txw + 1'b1;
        end
        if (rpop) begin
          c_next.rxr = c_reg.rxr + 1'b1;
        end
        pop = 1'b0;
        go = 1'b0;
      end
      if (pop || go) begin
        c_next.cur_word = w;
        c_next.cur_3w = (frame_format_sel_i == spm_pkg::FMT_THREE_WIRE);
        c_next.cur_bits = frame_bits(data_size_sel_i);
        c_next.cur_cmd = c_next.cur_3w ? frame_bits(command_size_sel_i) : 7'h00;
        c_next.req_tgl = ~c_reg.req_tgl;
        c_next.seq = spm_pkg::SEQ_WAIT;
      end
    end
    // Dummy phase ends once its count is used up
    if (c_next.rxcnt == '0) begin
      c_next.dummy_ph = 1'b0;
    end
    // Word finished on the link
    if (c_reg.seq == spm_pkg::SEQ_WAIT && dn_ev) begin
      c_next.seq = spm_pkg::SEQ_IDLE;
      if (c_reg.cur_store) begin
        c_next.tocnt = 6'h00;
        c_next.rto = 1'b0;
        if (c_reg.rxc == FULL) begin
          ovr_ev = !hw_flow_ctrl_i;
          c_next.ror = c_reg.ror | ovr_ev;
        end else begin
          rpush = 1'b1;
          c_next.rxm[c_reg.rxw] = l_reg.rxw;
          c_next.rxw = c_reg.rxw + 1'b1;
        end
      end
    end
    c_next.txc = c_reg.txc + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    c_next.rxc = c_reg.rxc + {{AW{1'b0}}, rpush} - {{AW{1'b0}}, rpop};
    // Software clears; a same-cycle set still wins
    if (irq_clear_port_i[spm_pkg::IRQ_OVERRUN] && !ovr_ev) begin
      c_next.ror = 1'b0;
    end
    if (irq_clear_port_i[spm_pkg::IRQ_UNDERRUN] && !(go && udr_ev)) begin
      c_next.tur = 1'b0;
    end
    if (irq_clear_port_i[spm_pkg::IRQ_TIMEOUT] || c_next.rxc == '0) begin
      c_next.rto = 1'b0;
      c_next.tocnt = 6'h00;
    end
    // Timeout counts serial periods with data waiting
    if (tk_ev && c_next.rxc != '0 && !rpush) begin
      if (c_reg.tocnt == spm_pkg::TIMEOUT_SCK - 6'h01) begin
        c_next.rto = 1'b1;
      end
      if (c_reg.tocnt != spm_pkg::TIMEOUT_SCK) begin
        c_next.tocnt = c_reg.tocnt + 6'h01;
      end
    end
    // Software loads of the frame counters take priority
    if (rx_frm_wr_i) begin
      c_next.rxcnt = rx_frm_data_i;
    end
    if (tx_frm_wr_i) begin
      c_next.txfcnt = tx_frm_data_i;
    end
  end

  // Core registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      c_reg <= '0;
    end else if (!c_reg.rst[1]) begin
      c_reg <= '0;
      c_reg.rst <= c_next.rst;
    end else begin
      c_reg <= c_next;
    end
  end

  // Link next state
  always_comb begin
    logic rq_ev;
    logic [6:0] first;
    rq_ev = 1'b0;
    first = 7'h00;
    l_next = l_reg;
    l_next.rst = {l_reg.rst[0], 1'b1};
    // Request toggle passes three flops; word fields are held still meanwhile
    l_next.rq_s = {l_reg.rq_s[1:0], c_reg.req_tgl};
    rq_ev = (l_reg.rq_s[1] == l_reg.rq_s[2]) && (l_reg.rq_s[2] != l_reg.rq_seen);
    // Free tick, one per serial period, feeds the timeout
    l_next.fdiv = ~l_reg.fdiv;
    if (l_reg.fdiv) begin
      l_next.tick_tgl = ~l_reg.tick_tgl;
    end
    case (l_reg.st)
      spm_pkg::LNK_IDLE: begin
        if (rq_ev) begin
          l_next.rq_seen = l_reg.rq_s[2];
          l_next.three = c_reg.cur_3w;
          l_next.cmd = c_reg.cur_cmd;
          l_next.total = c_reg.cur_bits + c_reg.cur_cmd;
          first = c_reg.cur_3w ? c_reg.cur_cmd : c_reg.cur_bits;
          l_next.sh = c_reg.cur_word << (7'h20 - first);
          l_next.rxsh = spm_pkg::WORD_RST;
          l_next.idx = spm_pkg::BITS_RST;
          l_next.cs_n = 1'b0;
          l_next.oe = 1'b1;
          l_next.st = spm_pkg::LNK_SHIFT;
        end
      end
      spm_pkg::LNK_SHIFT: begin
        if (!l_reg.sck) begin
          l_next.sck = 1'b1;
          if (l_reg.idx >= l_reg.cmd) begin
            l_next.rxsh = {l_reg.rxsh[30:0], sin_i}; // Data phase only
          end
        end else begin
          l_next.sck = 1'b0;
          l_next.sh = {l_reg.sh[30:0], 1'b0};
          l_next.idx = l_reg.idx + 7'h01;
          l_next.oe = !l_reg.three || (l_reg.idx + 7'h01 < l_reg.cmd);
          if (l_reg.idx + 7'h01 == l_reg.total) begin
            l_next.st = spm_pkg::LNK_END;
          end
        end
      end
      spm_pkg::LNK_END: begin
        l_next.cs_n = 1'b1;
        l_next.oe = !l_reg.three;
        l_next.rxw = l_reg.rxsh;
        l_next.done_tgl = ~l_reg.done_tgl;
        l_next.st = spm_pkg::LNK_IDLE;
      end
      default: begin
        l_next.st = spm_pkg::LNK_IDLE;
      end
    endcase
  end

  // Link registers; reset released by two flops of this clock
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      l_reg <= '0;
      l_reg.cs_n <= 1'b1;
    end else if (!l_reg.rst[1]) begin
      l_reg <= '0;
      l_reg.cs_n <= 1'b1;
      l_reg.rst <= l_next.rst;
    end else begin
      l_reg <= l_next;
    end
  end

  // Interrupt sources and outputs
  always_comb begin
    irq_raw_o = '0;
    irq_raw_o[spm_pkg::IRQ_RX] = (c_reg.rxc >= rx_watermark_i);
    irq_raw_o[spm_pkg::IRQ_TX] = (c_reg.txc <= tx_watermark_i);
    irq_raw_o[spm_pkg::IRQ_TIMEOUT] = c_reg.rto;
    irq_raw_o[spm_pkg::IRQ_OVERRUN] = c_reg.ror;
    irq_raw_o[spm_pkg::IRQ_UNDERRUN] = c_reg.tur;
    irq_raw_o[spm_pkg::IRQ_TXEMPTY] = (c_reg.txc == '0);
  end
  assign irq_o = |(irq_raw_o & irq_mask_bits_i);
  assign busy_o = (c_reg.seq == spm_pkg::SEQ_WAIT);
  assign tx_ready_o = (c_reg.txc != FULL);
  assign rx_valid_o = (c_reg.rxc != '0);
  assign rx_data_o = c_reg.rxm[c_reg.rxr];
  assign tx_level_o = c_reg.txc;
  assign rx_level_o = c_reg.rxc;
  assign rx_frame_count_o = c_reg.rxcnt;
  assign tx_frame_count_o = c_reg.txfcnt;
  assign sck_o = l_reg.sck;
  assign cs_n_o = l_reg.cs_n;
  assign sout_o = l_reg.sh[31];
  assign sout_oe_o = l_reg.oe;
endmodule
`default_nettype wire

/* File: design/spm_pkg.sv */
package spm_pkg;
  // Master transfer mode encodings
  localparam logic [1:0] MODE_DUPLEX = 2'h0;
  localparam logic [1:0] MODE_TXONLY = 2'h1;
  localparam logic [1:0] MODE_RECV = 2'h2;
  localparam logic [1:0] MODE_COMBINED = 2'h3;
  // Frame format encodings
  localparam logic [1:0] FMT_FOUR_WIRE = 2'h0;
  localparam logic [1:0] FMT_THREE_WIRE = 2'h2;
  // Interrupt source bit positions
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_OVERRUN = 3;
  localparam int IRQ_UNDERRUN = 4;
  localparam int IRQ_TXEMPTY = 5;
  localparam int IRQ_N = 6;
  // Smallest legal size field (4-bit frame)
  localparam logic [4:0] SIZE_MIN = 5'h03;
  // Receive timeout in serial clock periods
  localparam logic [5:0] TIMEOUT_SCK = 6'h20;
  // Counter in use while combined mode runs
  localparam logic [1:0] USE_NONE = 2'h0;
  localparam logic [1:0] USE_TXCNT = 2'h1;
  localparam logic [1:0] USE_RXCNT = 2'h2;
  // Reset values
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [6:0] BITS_RST = 7'h00;
  // Sequencer and link states
  typedef enum logic {SEQ_IDLE, SEQ_WAIT} spm_seq_type;
  typedef enum logic [1:0] {LNK_IDLE, LNK_SHIFT, LNK_END} spm_lnk_type;
endpackage

/* File: tb/spm_master_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module spm_master_chk #(
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk_i, // Core clock
  input wire logic rstn_i, // Reset, active low
  input wire logic link_clk_i, // Link clock
  input wire logic [1:0] frame_format_sel_i, // Format
  input wire logic [4:0] data_size_sel_i, // Frame bits minus one
  input wire logic hw_flow_ctrl_i, // Flow control
  input wire logic [AW:0] rx_watermark_i, // Rx mark
  input wire logic [AW:0] tx_watermark_i, // Tx mark
  input wire logic [5:0] irq_mask_bits_i, // Mask
  input wire logic [5:0] irq_clear_port_i, // Clear pulses
  input wire logic [5:0] irq_raw_o, // Raw sources
  input wire logic irq_o, // Combined line
  input wire logic busy_o, // Exchange in flight
  input wire logic [AW:0] tx_level_o, // Tx level
  input wire logic [AW:0] rx_level_o, // Rx level
  input wire logic sck_o, // Serial clock
  input wire logic cs_n_o // Select, active low
);
  logic sck_q_reg; // Sck one link cycle ago
  logic [6:0] rise_reg; // Sck rises seen in this frame
  // Count clock rises while selected; cleared between frames
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_q_reg <= 1'b0;
      rise_reg <= 7'h00;
    end else begin
      sck_q_reg <= sck_o;
      if (cs_n_o) rise_reg <= 7'h00;
      else if (sck_o && !sck_q_reg) rise_reg <= rise_reg + 7'h01;
    end
  end
  property p_irq_line;
    @(posedge clk_i) disable iff (!rstn_i) irq_o == |(irq_raw_o & irq_mask_bits_i);
  endproperty
  a_irq_line: assert property (p_irq_line)
    else $error("combined line disagrees with masked sources");
  // Guarded by stable inputs so a one-cycle flag lag is tolerated
  property p_rx_mark;
    @(posedge clk_i) disable iff (!rstn_i) $stable(rx_level_o) && $stable(rx_watermark_i)
      |-> irq_raw_o[spm_pkg::IRQ_RX] == (rx_level_o >= rx_watermark_i);
  endproperty
  a_rx_mark: assert property (p_rx_mark)
    else $error("rx level flag wrong");
  property p_tx_mark;
    @(posedge clk_i) disable iff (!rstn_i) $stable(tx_level_o) && $stable(tx_watermark_i)
      |-> irq_raw_o[spm_pkg::IRQ_TX] == (tx_level_o <= tx_watermark_i);
  endproperty
  a_tx_mark: assert property (p_tx_mark)
    else $error("tx level flag wrong");
  property p_tx_empty;
    @(posedge clk_i) disable iff (!rstn_i)
      $stable(tx_level_o) |-> irq_raw_o[spm_pkg::IRQ_TXEMPTY] == (tx_level_o == '0);
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("tx empty flag wrong");
  property p_ovr_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      irq_raw_o[spm_pkg::IRQ_OVERRUN] && !irq_clear_port_i[spm_pkg::IRQ_OVERRUN]
      |=> irq_raw_o[spm_pkg::IRQ_OVERRUN];
  endproperty
  a_ovr_hold: assert property (p_ovr_hold)
    else $error("overrun flag dropped without clear");
  property p_udr_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      irq_raw_o[spm_pkg::IRQ_UNDERRUN] && !irq_clear_port_i[spm_pkg::IRQ_UNDERRUN]
      |=> irq_raw_o[spm_pkg::IRQ_UNDERRUN];
  endproperty
  a_udr_hold: assert property (p_udr_hold)
    else $error("underrun flag dropped without clear");
  property p_no_ovr;
    @(posedge clk_i) disable iff (!rstn_i)
      hw_flow_ctrl_i && $past(hw_flow_ctrl_i) |-> !$rose(irq_raw_o[spm_pkg::IRQ_OVERRUN]);
  endproperty
  a_no_ovr: assert property (p_no_ovr)
    else $error("overrun raised under flow control");
  property p_to_empty;
    @(posedge clk_i) disable iff (!rstn_i)
      rx_level_o == '0 && $past(rx_level_o) == '0 |-> !irq_raw_o[spm_pkg::IRQ_TIMEOUT];
  endproperty
  a_to_empty: assert property (p_to_empty)
    else $error("timeout flag set with empty queue");
  // Select low only inside the busy span seen by the core
  property p_busy_cs;
    @(posedge clk_i) disable iff (!rstn_i) !cs_n_o |-> busy_o;
  endproperty
  a_busy_cs: assert property (p_busy_cs)
    else $error("slave selected while not busy");
  property p_launch;
    @(posedge clk_i) disable iff (!rstn_i) $rose(busy_o) |-> ##[1:20] !cs_n_o;
  endproperty
  a_launch: assert property (p_launch)
    else $error("busy without a frame on the link");
  property p_frame_bits;
    @(posedge link_clk_i) disable iff (!rstn_i)
      $rose(cs_n_o) && frame_format_sel_i == spm_pkg::FMT_FOUR_WIRE
      |-> rise_reg == {2'h0, data_size_sel_i} + 7'h01;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame clock count wrong");
endmodule
bind spm_master spm_master_chk #(.DEPTH(DEPTH), .AW(AW)) chk (
  .clk_i, .rstn_i, .link_clk_i, .frame_format_sel_i, .data_size_sel_i,
  .hw_flow_ctrl_i, .rx_watermark_i, .tx_watermark_i, .irq_mask_bits_i,
  .irq_clear_port_i, .irq_raw_o, .irq_o, .busy_o, .tx_level_o, .rx_level_o,
  .sck_o, .cs_n_o
);
`default_nettype wire

/* File: tb/spm_slave_model.sv */
`timescale 1ns/10ps
`default_nettype none
module spm_slave_model (
  input wire logic sck_i, // Serial clock
  input wire logic cs_n_i, // Select, active low
  input wire logic mosi_i, // Master out
  input wire logic oe_i, // Master drives the line
  input wire logic three_i, // Shared-line format
  input wire logic [31:0] resp_i, // Answer word
  input wire logic [5:0] bits_i, // Answer length
  output logic sin_o, // Line seen by master
  output logic [31:0] heard_o // Bits taken from master
);
  logic [31:0] sh = 32'h0; // Answer shifter, MSB on the line
  logic idle = 1'b0; // Level while deselected
  logic primed = 1'b0; // A data bit was sampled
  initial heard_o = 32'h0;
  // Load answer left-aligned when selected
  always @(negedge cs_n_i) begin
    sh = resp_i << (6'h20 - bits_i);
    heard_o = 32'h0;
    primed = 1'b0;
  end
  // Deselected line flips so a stale bit never reads as valid
  always @(posedge cs_n_i) idle = ~sh[31];
  // Arm on a data-sampling rise; oe never moves on a rising clock, so no race
  always @(posedge sck_i) if (!cs_n_i && !(three_i && oe_i)) primed = 1'b1;
  // Next bit after each falling clock once the first data bit was taken
  always @(negedge sck_i) if (!cs_n_i && primed) sh = sh << 1;
  // Capture master bits on rising clock while it drives
  always @(posedge sck_i) if (!cs_n_i && oe_i) heard_o = {heard_o[30:0], mosi_i};
  // One wire in shared mode: master wins while enabled
  assign sin_o = (three_i && oe_i) ? mosi_i : (cs_n_i ? idle : sh[31]);
endmodule
`default_nettype wire

/* File: tb/spm_master_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module spm_master_tb;
  localparam logic [31:0] W1 = 32'h3c00003c; // Same byte at both ends
  localparam logic [31:0] W2 = 32'hc30000c3; // Second pattern
  localparam logic [31:0] RSP = 32'h000000a5; // Slave answer
  localparam logic [31:0] DUM = 32'h5a00005a; // Dummy word
  logic clk_i = 1'b0, link_clk_i = 1'b0, rstn_i = 1'b0; // Clocks, reset
  logic port_enable_bit_i = 1'b0, hw_flow_ctrl_i = 1'b0, continuous_i = 1'b0;
  logic rx_frm_wr_i = 1'b0, tx_frm_wr_i = 1'b0; // Count loads
  logic tx_valid_i = 1'b0, rx_ready_i = 1'b0, sin_i; // Queue strobes, line
  logic [1:0] frame_format_sel_i = 2'h0, master_xfer_mode_i = 2'h0;
  logic [4:0] data_size_sel_i = 5'h07, command_size_sel_i = 5'h07; // 8-bit
  logic [4:0] rx_watermark_i = 5'h02, tx_watermark_i = 5'h01, tx_level_o, rx_level_o;
  logic [5:0] irq_mask_bits_i = 6'h00, irq_clear_port_i = 6'h00, irq_raw_o;
  logic [31:0] rx_frm_data_i = 32'h0, tx_frm_data_i = 32'h0, tx_data_i = 32'h0;
  logic [31:0] rx_frame_count_o, tx_frame_count_o, rx_data_o, heard;
  logic irq_o, busy_o, tx_ready_o, rx_valid_o, sck_o, cs_n_o, sout_o, sout_oe_o;
  int err_count = 0, tests_run = 0;
  always #4 clk_i = ~clk_i;
  always #7.5 link_clk_i = ~link_clk_i;
  spm_master uut (.clk_i, .rstn_i, .link_clk_i, .port_enable_bit_i, .frame_format_sel_i,
    .master_xfer_mode_i, .data_size_sel_i, .command_size_sel_i, .dummy_char_value_i(DUM),
    .hw_flow_ctrl_i, .continuous_i, .rx_watermark_i, .tx_watermark_i, .rx_frm_wr_i,
    .rx_frm_data_i, .tx_frm_wr_i, .tx_frm_data_i, .rx_frame_count_o, .tx_frame_count_o,
    .irq_mask_bits_i, .irq_clear_port_i, .irq_raw_o, .irq_o, .busy_o, .tx_valid_i,
    .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .tx_level_o,
    .rx_level_o, .sck_o, .cs_n_o, .sout_o, .sout_oe_o, .sin_i);
  spm_slave_model slave (.sck_i(sck_o), .cs_n_i(cs_n_o), .mosi_i(sout_o),
    .oe_i(sout_oe_o), .three_i(frame_format_sel_i == spm_pkg::FMT_THREE_WIRE),
    .resp_i(RSP), .bits_i(6'h08), .sin_o(sin_i), .heard_o(heard));
  task automatic test_done;
    $display("mismatches %0d, checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs move just after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Push n copies; waits on ready so a full queue only stalls
  task automatic push(input logic [31:0] w, input int n);
    tx_data_i = w;
    tx_valid_i = 1'b1;
    repeat (n) begin
      while (tx_ready_o !== 1'b1) cyc(1);
      cyc(1);
    end
    tx_valid_i = 1'b0;
    cyc(1);
  endtask
  task automatic pop(input int n);
    rx_ready_i = 1'b1;
    repeat (n) begin
      chk(32'(rx_valid_o), 32'h1);
      chk(rx_data_o, RSP);
      cyc(1);
    end
    rx_ready_i = 1'b0;
  endtask
  // Bounded wait for one busy span; returns on the first idle cycle
  task automatic frame;
    int i;
    for (i = 0; i < 100 && busy_o !== 1'b1; i++) cyc(1);
    for (i = 0; i < 200 && busy_o !== 1'b0; i++) cyc(1);
  endtask
  task automatic ld(input logic [31:0] rx, input logic [31:0] tx);
    rx_frm_data_i = rx;
    tx_frm_data_i = tx;
    rx_frm_wr_i = 1'b1;
    tx_frm_wr_i = 1'b1;
    cyc(1);
    rx_frm_wr_i = 1'b0;
    tx_frm_wr_i = 1'b0;
  endtask
  task automatic clr(input logic [5:0] b);
    irq_clear_port_i = b;
    cyc(1);
    irq_clear_port_i = 6'h00;
    cyc(1);
  endtask
  // Watchdog: whole run needs far less than this
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    cyc(3);
    chk(32'(irq_raw_o), 32'h22);
    irq_mask_bits_i = 6'h20;
    cyc(1);
    chk(32'(irq_o), 32'h1);
    irq_mask_bits_i = 6'h01;
    cyc(1);
    chk(32'(irq_o), 32'h0);
    irq_mask_bits_i = 6'h3f;
    // Queue fills while disabled
    push(W1, 1);
    chk(32'(irq_raw_o), 32'h02);
    push(W1, 1);
    chk(32'(irq_raw_o), 32'h00);
    chk(32'(tx_level_o), 32'h2);
    port_enable_bit_i = 1'b1;
    frame();
    chk(heard, 32'h3c);
    frame();
    chk(32'(rx_level_o), 32'h2);
    chk(32'(irq_raw_o), 32'h23);
    pop(1);
    chk(32'(irq_raw_o[0]), 32'h0);
    cyc(90);
    chk(32'(irq_raw_o[2]), 32'h0);
    cyc(50);
    chk(32'(irq_raw_o[2]), 32'h1);
    clr(6'h04);
    chk(32'(irq_raw_o[2]), 32'h0);
    pop(1);
    // Transmit only
    master_xfer_mode_i = spm_pkg::MODE_TXONLY;
    push(W2, 1);
    frame();
    chk(heard, 32'hc3);
    chk(32'(rx_level_o), 32'h0);
    // Receive: queued word first, then dummies
    master_xfer_mode_i = spm_pkg::MODE_RECV;
    push(W1, 1);
    ld(32'h2, 32'h0);
    frame();
    chk(heard, 32'h3c);
    chk(rx_frame_count_o, 32'h2);
    push(W2, 1);
    frame();
    chk(heard, 32'h5a);
    chk(rx_frame_count_o, 32'h1);
    frame();
    chk(heard, 32'h5a);
    chk(rx_frame_count_o, 32'h0);
    cyc(80);
    chk(32'(busy_o), 32'h0);
    pop(3);
    // Combined: W2 still queued
    master_xfer_mode_i = spm_pkg::MODE_COMBINED;
    ld(32'h1, 32'h1);
    frame();
    chk(heard, 32'hc3);
    chk(tx_frame_count_o, 32'h0);
    chk(rx_frame_count_o, 32'h1);
    frame();
    chk(heard, 32'h5a);
    chk(rx_frame_count_o, 32'h0);
    ld(32'h0, 32'h1);
    cyc(80);
    chk(32'(busy_o), 32'h0);
    chk(tx_frame_count_o, 32'h1);
    pop(2);
    // Overrun, then flow control
    master_xfer_mode_i = spm_pkg::MODE_DUPLEX;
    push(W1, 17);
    cyc(900);
    chk(32'(rx_level_o), 32'h10);
    chk(32'(irq_raw_o[3]), 32'h1);
    clr(6'h08);
    chk(32'(irq_raw_o[3]), 32'h0);
    hw_flow_ctrl_i = 1'b1;
    push(W1, 1);
    cyc(100);
    chk(32'(irq_raw_o[3]), 32'h0);
    port_enable_bit_i = 1'b0;
    hw_flow_ctrl_i = 1'b0;
    pop(16);
    // Underrun repeats the stale word
    continuous_i = 1'b1;
    port_enable_bit_i = 1'b1;
    frame();
    frame();
    continuous_i = 1'b0;
    chk(heard, 32'h3c);
    chk(32'(irq_raw_o[4]), 32'h1);
    cyc(60);
    clr(6'h10);
    chk(32'(irq_raw_o[4]), 32'h0);
    pop(32'(rx_level_o));
    // Shared-line command then answer
    frame_format_sel_i = spm_pkg::FMT_THREE_WIRE;
    push(W2, 1);
    frame();
    chk(heard, 32'hc3);
    pop(1);
    port_enable_bit_i = 1'b0;
    test_done();
  end
endmodule
`default_nettype wire
